// ### core/ssir_pkg.sv
// constants, layouts and state types of the sleep, status and identity register block
`default_nettype none
package ssir_pkg;

	// timing
	localparam int CLK_HZ            = 200_000_000;
	localparam int SLEEP_STEP_MS     = 500;
	localparam int SLEEP_STEP_CYCLES = (CLK_HZ / 1000) * SLEEP_STEP_MS;
	localparam int PRE_W             = 27;

	// serial word layout
	localparam int         WORD_BITS  = 16;
	localparam int         CMD_WR_POS = 15;
	localparam int         ADDR_MSB   = 14;
	localparam int         ADDR_LSB   = 8;
	localparam logic [3:0] LAST_BIT   = 4'hF;

	// register addresses
	localparam logic [6:0] ADDR_SLEEP   = 7'h24;
	localparam logic [6:0] ADDR_DIAG    = 7'h26;
	localparam logic [6:0] ADDR_LOT1    = 7'h32;
	localparam logic [6:0] ADDR_LOT2    = 7'h34;
	localparam logic [6:0] ADDR_LOT3    = 7'h36;
	localparam logic [6:0] ADDR_PRODUCT = 7'h38;
	localparam logic [6:0] ADDR_SERIAL  = 7'h3A;

	// sleep control values
	localparam logic [7:0] SLEEP_FOREVER = 8'hFF;
	localparam logic [7:0] SLEEP_NONE    = 8'h00;
	localparam logic [7:0] SLEEP_RESET   = 8'h00;

	// diagnostic flag positions
	localparam int          DIAG_SUPPLY    = 0;
	localparam int          DIAG_FLASH_UPD = 2;
	localparam int          DIAG_COMM      = 3;
	localparam int          DIAG_OVER      = 4;
	localparam int          DIAG_SELFTEST  = 5;
	localparam int          DIAG_CHECKSUM  = 6;
	localparam int          DIAG_ALARM1    = 8;
	localparam int          DIAG_ALARM2    = 9;
	localparam logic [15:0] DIAG_RESET     = 16'h0000;
	localparam logic [15:0] DIAG_USED      = 16'h037D;

	// identity limits
	localparam logic [15:0] SERIAL_MASK = 16'h3FFF;
	localparam int          SERIAL_MIN  = 1;
	localparam int          SERIAL_MAX  = 9999;

	// synchroniser reset patterns
	localparam logic [2:0] SYNC_HIGH = 3'h7;
	localparam logic [2:0] SYNC_LOW  = 3'h0;

	typedef enum logic [2:0] {
		SSIR_AWAKE     = 3'b001,
		SSIR_NAP_HOLD  = 3'b010,
		SSIR_NAP_TIMED = 3'b100
	} ssir_mode_t;

	typedef struct packed {
		logic             rst;
		logic [2:0]       cs_s;
		logic             cs_f;
		logic [2:0]       tog_s;
		logic             tog_f;
		logic [2:0]       part_s;
		logic             part_f;
		logic [2:0]       hrst_s;
		logic             hrst_f;
		logic [7:0]       sleep_ctl;
		logic [15:0]      diag;
		logic [15:0]      rd_word;
		ssir_mode_t       mode;
		logic [7:0]       remain;
		logic [PRE_W-1:0] pre;
		logic             samp;
		logic             sleep;
	} ssir_sys_t;

	typedef struct packed {
		logic [14:0] sh;
		logic [15:0] word;
		logic        tog;
		logic        part;
	} ssir_link_t;

	typedef struct packed {
		logic [3:0] cnt;
	} ssir_cnt_t;

	typedef struct packed {
		logic miso;
	} ssir_tx_t;

	localparam ssir_sys_t SYS_RESET = '{
		rst: 1'b1, cs_s: SYNC_HIGH, cs_f: 1'b1, tog_s: SYNC_LOW, tog_f: 1'b0,
		part_s: SYNC_LOW, part_f: 1'b0, hrst_s: SYNC_HIGH, hrst_f: 1'b1,
		sleep_ctl: SLEEP_RESET, diag: DIAG_RESET, rd_word: 16'h0000,
		mode: SSIR_AWAKE, remain: 8'h00, pre: 27'h0000000, samp: 1'b1, sleep: 1'b0
	};
	localparam ssir_link_t LINK_RESET = '{sh: 15'h0000, word: 16'h0000, tog: 1'b0, part: 1'b0};
	localparam ssir_cnt_t  CNT_RESET  = '{cnt: 4'h0};
	localparam ssir_tx_t   TX_RESET   = '{miso: 1'b0};

endpackage : ssir_pkg
`default_nettype wire

// ### core/ssir_regs.sv
// serial register block: sleep control, diagnostic flags and identity registers
`default_nettype none

// Behaviour
// - 0xFF in sleep byte: sleep until woken
// - chip-select fall or reset pulse wakes device
// - 0x00..0xFE sleeps value times half second
// - each flag reads one while error present
// - reading flags returns them, then clears all
// - persisting error sets flag at next sample
// - supply-low flag clears when supply recovers
// - frame edge count not multiple sixteen: flag
// - bits nine, eight show alarm two, one
// - bit six checksum fail, five self-test fail
// - bit four over-range, three comm, two flash fail, zero supply-low; rest zero
// - flag register resets to all zero
// - product code reads fixed sixteen-bit value
// - three lot codes read fixed values
// - serial number fourteen bits, one to 9999
module ssir_regs #(
	parameter int          STEP_CYCLES  = ssir_pkg::SLEEP_STEP_CYCLES,
	parameter logic [15:0] PRODUCT_CODE = 16'h5A5A, // value arbitrary
	parameter logic [15:0] LOT_CODE1    = 16'h0001, // value arbitrary
	parameter logic [15:0] LOT_CODE2    = 16'h0002, // value arbitrary
	parameter logic [15:0] LOT_CODE3    = 16'h0003, // value arbitrary
	parameter logic [15:0] SERIAL_CODE  = 16'h0001  // value arbitrary
) (
	// system clock and reset
	input  wire logic CLK_IN,
	input  wire logic SYS_RST_IN,
	// serial link
	input  wire logic SCLK_IN,
	input  wire logic CS_N_IN,
	input  wire logic MOSI_IN,
	output var  logic MISO_OUT,
	// hard reset pin
	input  wire logic HARD_RST_N_IN,
	// sensor datapath conditions
	input  wire logic SAMPLE_TICK_IN,
	input  wire logic SUPPLY_LOW_IN,
	input  wire logic FLASH_FAIL_IN,
	input  wire logic OVER_RANGE_IN,
	input  wire logic SELF_TEST_FAIL_IN,
	input  wire logic CHECKSUM_FAIL_IN,
	input  wire logic ALARM1_IN,
	input  wire logic ALARM2_IN,
	// power state
	output var  logic SLEEP_OUT,
	output var  logic SAMPLING_OUT
);

	if (STEP_CYCLES < 1 || STEP_CYCLES > (2 ** ssir_pkg::PRE_W)) begin : g_bad_step
		$error("STEP_CYCLES does not fit the sleep prescaler");
	end
	if (int'(SERIAL_CODE & ssir_pkg::SERIAL_MASK) < ssir_pkg::SERIAL_MIN ||
	    int'(SERIAL_CODE & ssir_pkg::SERIAL_MASK) > ssir_pkg::SERIAL_MAX) begin : g_bad_serial
		$error("SERIAL_CODE outside one to 9999");
	end

	localparam logic [ssir_pkg::PRE_W-1:0] PRE_RELOAD = ssir_pkg::PRE_W'(STEP_CYCLES - 1);

	ssir_pkg::ssir_sys_t  s;
	ssir_pkg::ssir_sys_t  n;
	ssir_pkg::ssir_link_t lq;
	ssir_pkg::ssir_link_t ln;
	ssir_pkg::ssir_cnt_t  cq;
	ssir_pkg::ssir_cnt_t  cn;
	ssir_pkg::ssir_tx_t   tq;
	ssir_pkg::ssir_tx_t   tn;

	// a change counts once the second and third stages agree
	function automatic logic filt(input logic [2:0] sync, input logic held);
		return (sync[1] == sync[2]) ? sync[2] : held;
	endfunction

	function automatic logic [15:0] reg_read(input logic [6:0] a,
	                                         input logic [7:0] slp,
	                                         input logic [15:0] dg);
		case (a)
			ssir_pkg::ADDR_SLEEP:   return {8'h00, slp};
			ssir_pkg::ADDR_DIAG:    return dg;
			ssir_pkg::ADDR_LOT1:    return LOT_CODE1;
			ssir_pkg::ADDR_LOT2:    return LOT_CODE2;
			ssir_pkg::ADDR_LOT3:    return LOT_CODE3;
			ssir_pkg::ADDR_PRODUCT: return PRODUCT_CODE;
			ssir_pkg::ADDR_SERIAL:  return SERIAL_CODE & ssir_pkg::SERIAL_MASK;
			default:                return 16'h0000;
		endcase
	endfunction

	// crossing events into the system domain
	logic        cs_new;
	logic        tog_new;
	logic        part_new;
	logic        hrst_new;
	logic        cs_fall;
	logic        cs_rise;
	logic        word_evt;
	logic        hrst_rise;
	logic        wake;
	logic        awake;
	logic        tick;
	logic        frame_bad;
	logic [15:0] rx_word;
	logic [6:0]  cmd_addr;
	logic [7:0]  cmd_data;
	logic        cmd_rd;
	logic        sleep_wr;
	logic        rd_diag;
	logic [15:0] cond;

	assign cs_new    = filt(s.cs_s, s.cs_f);
	assign tog_new   = filt(s.tog_s, s.tog_f);
	assign part_new  = filt(s.part_s, s.part_f);
	assign hrst_new  = filt(s.hrst_s, s.hrst_f);
	assign cs_fall   = s.cs_f & ~cs_new;
	assign cs_rise   = ~s.cs_f & cs_new;
	assign word_evt  = tog_new ^ s.tog_f;
	assign hrst_rise = ~s.hrst_f & hrst_new;
	assign wake      = cs_fall | hrst_rise;
	assign awake     = (s.mode == ssir_pkg::SSIR_AWAKE);
	assign tick      = SAMPLE_TICK_IN & awake;
	// the partial-word level settled at the last edge, before chip select rose
	assign frame_bad = cs_rise & part_new;
	// the captured word holds for 16 link edges, far longer than the sync path
	assign rx_word   = lq.word;
	assign cmd_addr  = rx_word[ssir_pkg::ADDR_MSB:ssir_pkg::ADDR_LSB];
	assign cmd_data  = rx_word[7:0];
	assign cmd_rd    = word_evt & ~rx_word[ssir_pkg::CMD_WR_POS];
	assign sleep_wr  = word_evt & rx_word[ssir_pkg::CMD_WR_POS] &
	                   (cmd_addr == ssir_pkg::ADDR_SLEEP);
	assign rd_diag   = cmd_rd & (cmd_addr == ssir_pkg::ADDR_DIAG);

	always_comb begin
		cond                           = 16'h0000;
		cond[ssir_pkg::DIAG_SUPPLY]    = SUPPLY_LOW_IN;
		cond[ssir_pkg::DIAG_FLASH_UPD] = FLASH_FAIL_IN;
		cond[ssir_pkg::DIAG_OVER]      = OVER_RANGE_IN;
		cond[ssir_pkg::DIAG_SELFTEST]  = SELF_TEST_FAIL_IN;
		cond[ssir_pkg::DIAG_CHECKSUM]  = CHECKSUM_FAIL_IN;
		cond[ssir_pkg::DIAG_ALARM1]    = ALARM1_IN;
		cond[ssir_pkg::DIAG_ALARM2]    = ALARM2_IN;
	end

	always_comb begin
		n        = s;
		n.rst    = 1'b0;
		n.cs_s   = {s.cs_s[1:0], CS_N_IN};
		n.tog_s  = {s.tog_s[1:0], lq.tog};
		n.part_s = {s.part_s[1:0], lq.part};
		n.hrst_s = {s.hrst_s[1:0], HARD_RST_N_IN};
		n.cs_f   = cs_new;
		n.tog_f  = tog_new;
		n.part_f = part_new;
		n.hrst_f = hrst_new;

		if (cmd_rd) begin
			n.rd_word = reg_read(cmd_addr, s.sleep_ctl, s.diag);
		end
		// clears first, sets after, so an event in the clearing cycle survives
		if (rd_diag) begin
			n.diag = ssir_pkg::DIAG_RESET;
		end
		if (tick) begin
			n.diag = n.diag | cond;
		end
		if (frame_bad) begin
			n.diag[ssir_pkg::DIAG_COMM] = 1'b1;
		end
		if (!SUPPLY_LOW_IN) begin
			n.diag[ssir_pkg::DIAG_SUPPLY] = 1'b0;
		end
		n.diag = n.diag & ssir_pkg::DIAG_USED;

		if (sleep_wr) begin
			n.sleep_ctl = cmd_data;
		end
		unique case (s.mode)
			ssir_pkg::SSIR_AWAKE: begin
				if (sleep_wr && cmd_data == ssir_pkg::SLEEP_FOREVER) begin
					n.mode = ssir_pkg::SSIR_NAP_HOLD;
				end else if (sleep_wr && cmd_data != ssir_pkg::SLEEP_NONE) begin
					n.mode   = ssir_pkg::SSIR_NAP_TIMED;
					n.remain = cmd_data;
					n.pre    = PRE_RELOAD;
				end
			end
			ssir_pkg::SSIR_NAP_HOLD: begin
				if (wake) begin
					n.mode = ssir_pkg::SSIR_AWAKE;
				end
			end
			ssir_pkg::SSIR_NAP_TIMED: begin
				if (wake) begin
					n.mode = ssir_pkg::SSIR_AWAKE;
				end else if (s.pre == '0) begin
					if (s.remain == 8'h01) begin
						n.mode = ssir_pkg::SSIR_AWAKE;
					end else begin
						n.remain = s.remain - 8'h01;
						n.pre    = PRE_RELOAD;
					end
				end else begin
					n.pre = s.pre - 27'h0000001;
				end
			end
		endcase
		n.samp  = (n.mode == ssir_pkg::SSIR_AWAKE);
		n.sleep = ~n.samp;
	end

	always_ff @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			s <= ssir_pkg::SYS_RESET;
		end else begin
			s <= n;
		end
	end

	// link domain; chip select ends the frame since the link clock stops with it
	logic cnt_rst;
	logic link_rst;
	assign cnt_rst  = CS_N_IN | s.rst;
	assign link_rst = s.rst;

	always_comb begin
		cn.cnt = cq.cnt + 4'h1;
	end

	always_ff @(posedge SCLK_IN or posedge cnt_rst) begin
		if (cnt_rst) begin
			cq <= ssir_pkg::CNT_RESET;
		end else begin
			cq <= cn;
		end
	end

	always_comb begin
		ln      = lq;
		ln.sh   = {lq.sh[13:0], MOSI_IN};
		ln.part = (cq.cnt != ssir_pkg::LAST_BIT);
		if (cq.cnt == ssir_pkg::LAST_BIT) begin
			ln.word = {lq.sh, MOSI_IN};
			ln.tog  = ~lq.tog;
		end
	end

	always_ff @(posedge SCLK_IN or posedge link_rst) begin
		if (link_rst) begin
			lq <= ssir_pkg::LINK_RESET;
		end else begin
			lq <= ln;
		end
	end

	// reply word is quasi-static: the host must leave a gap before the next frame
	always_comb begin
		tn.miso = s.rd_word[ssir_pkg::LAST_BIT - cq.cnt];
	end

	always_ff @(negedge SCLK_IN or posedge link_rst) begin
		if (link_rst) begin
			tq <= ssir_pkg::TX_RESET;
		end else begin
			tq <= tn;
		end
	end

	assign MISO_OUT     = tq.miso;
	assign SLEEP_OUT    = s.sleep;
	assign SAMPLING_OUT = s.samp;

	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (SYS_RST_IN);

	chk_sleep_enter: assert property (
		awake && sleep_wr && cmd_data == ssir_pkg::SLEEP_FOREVER
		|=> s.mode == ssir_pkg::SSIR_NAP_HOLD && SLEEP_OUT && !SAMPLING_OUT)
		else $error("indefinite sleep not entered");
	chk_hold_stays: assert property (
		s.mode == ssir_pkg::SSIR_NAP_HOLD && !wake |=> s.mode == ssir_pkg::SSIR_NAP_HOLD)
		else $error("indefinite sleep left without wake");
	chk_wake_cs: assert property (
		!awake && wake |=> SAMPLING_OUT && !SLEEP_OUT)
		else $error("wake event did not restore operation");
	chk_timed_load: assert property (
		awake && sleep_wr && cmd_data != ssir_pkg::SLEEP_FOREVER && cmd_data != 8'h00
		|=> s.mode == ssir_pkg::SSIR_NAP_TIMED && s.remain == $past(cmd_data) &&
		    s.pre == PRE_RELOAD)
		else $error("timed sleep not loaded");
	chk_timed_wake: assert property (
		s.mode == ssir_pkg::SSIR_NAP_TIMED && s.remain == 8'h01 && s.pre == '0
		|=> SAMPLING_OUT)
		else $error("timed sleep did not end");
	chk_flag_set: assert property (
		tick |=> (s.diag & $past(cond) & 16'hFFFE) == ($past(cond) & 16'hFFFE))
		else $error("present condition not flagged at sample");
	chk_read_clear: assert property (
		rd_diag && !tick && !frame_bad
		|=> s.diag == ssir_pkg::DIAG_RESET && s.rd_word == $past(s.diag))
		else $error("flag read did not return and clear");
	chk_supply_auto: assert property (
		!SUPPLY_LOW_IN |=> !s.diag[ssir_pkg::DIAG_SUPPLY])
		else $error("supply flag did not self clear");
	chk_comm_err: assert property (
		frame_bad |=> s.diag[ssir_pkg::DIAG_COMM])
		else $error("partial frame not flagged");
	chk_unused_zero: assert property (
		(s.diag & ~ssir_pkg::DIAG_USED) == 16'h0000)
		else $error("unused flag bit set");
	chk_reset_zero: assert property (disable iff (1'b0)
		SYS_RST_IN |=> s.diag == ssir_pkg::DIAG_RESET)
		else $error("flags not zero after reset");
	chk_product_read: assert property (
		cmd_rd && cmd_addr == ssir_pkg::ADDR_PRODUCT |=> s.rd_word == PRODUCT_CODE)
		else $error("product code read wrong");
	chk_serial_read: assert property (
		cmd_rd && cmd_addr == ssir_pkg::ADDR_SERIAL |=> s.rd_word[15:14] == 2'b00)
		else $error("serial upper bits not zero");
	// a timed sleep may run out in the same cycle, so sampling then resumes
	chk_sleep_halt: assert property (
		!awake && !wake && !s.diag[ssir_pkg::DIAG_OVER] && SAMPLE_TICK_IN
		|=> !s.diag[ssir_pkg::DIAG_OVER] &&
		    SAMPLING_OUT == ($past(s.mode) == ssir_pkg::SSIR_NAP_TIMED &&
		                     $past(s.remain) == 8'h01 && $past(s.pre) == '0))
		else $error("flag updated while asleep");
	chk_flags_hold: assert property (
		!tick && !rd_diag && !frame_bad |=> (s.diag & 16'hFFFE) == ($past(s.diag) & 16'hFFFE))
		else $error("flags changed with no event");
	chk_lot_read: assert property (
		cmd_rd && cmd_addr == ssir_pkg::ADDR_LOT1 |=> s.rd_word == LOT_CODE1)
		else $error("lot code read wrong");
	chk_serial_value: assert property (
		cmd_rd && cmd_addr == ssir_pkg::ADDR_SERIAL |=> s.rd_word[13:0] == SERIAL_CODE[13:0])
		else $error("serial number read wrong");

	cov_timed_wake: cover property (s.mode == ssir_pkg::SSIR_NAP_TIMED ##1 awake);
	cov_diag_read: cover property (rd_diag && s.diag != 16'h0000);
	cov_comm_err: cover property (frame_bad);
	cov_cs_wake: cover property (s.mode == ssir_pkg::SSIR_NAP_HOLD && cs_fall);

endmodule : ssir_regs
`default_nettype wire

// ### tb/ssir_host.sv
// host model: serial master sending framed 16-bit words, clock idle high
`default_nettype none
module ssir_host (
	// serial link
	output var  logic SCLK_OUT,
	output var  logic CS_N_OUT,
	output var  logic MOSI_OUT,
	input  wire logic MISO_IN
);
	timeunit 1ns;
	timeprecision 100ps;

	// select rises only once the device reset has begun, so the select-cleared bit
	// counter sees a real rising edge on its clear instead of a start-up race
	initial begin
		SCLK_OUT = 1'b1;
		CS_N_OUT = 1'b0;
		MOSI_OUT = 1'b0;
		#10;
		CS_N_OUT = 1'b1;
	end

	// the link clock stands still outside frames; nbits off a multiple of 16 makes a bad frame
	task automatic frame(input logic [15:0] w, input int nbits, output logic [15:0] r);
		r = 16'h0000;
		CS_N_OUT = 1'b0;
		#10;
		for (int k = 0; k < nbits; k++) begin
			SCLK_OUT = 1'b0;
			MOSI_OUT = w[15 - (k % 16)];
			#7.5;
			SCLK_OUT = 1'b1;
			r = {r[14:0], MISO_IN};
			#7.5;
		end
		#10;
		CS_N_OUT = 1'b1;
		// released data line must not keep showing the last bit
		MOSI_OUT = ~MOSI_OUT;
		// gap so a read reply is ready before the next word
		#100;
	endtask
endmodule // ssir_host
`default_nettype wire

// ### tb/tb.sv
// self-checking bench of the sleep, status and identity register block
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 100ps;

	logic        clk;
	logic        sys_rst;
	logic        sclk;
	logic        cs_n;
	logic        mosi;
	logic        miso;
	logic        hard_rst_n;
	logic        tick;
	logic [6:0]  cond;
	logic        sleep;
	logic        sampling;
	int          mismatches;
	int          n_checks;
	int          cycles;
	int          run;
	int          last_run;
	// flag bit raised by each cond input, in cond order
	localparam logic [15:0] FLAG [7] = '{16'h0001, 16'h0004, 16'h0010, 16'h0020, 16'h0040,
		16'h0100, 16'h0200};
	// sleep step shortened so timed sleeps fit the run
	localparam int          STEP     = 8;

	// identity values are arbitrary; serial sits at its top value
	ssir_regs #(
		.STEP_CYCLES (STEP),
		.PRODUCT_CODE(16'h1234),
		.LOT_CODE1   (16'h0A01),
		.LOT_CODE2   (16'h0A02),
		.LOT_CODE3   (16'h0A03),
		.SERIAL_CODE (16'h270F)
	) ssir_regs_inst (
		.CLK_IN(clk), .SYS_RST_IN(sys_rst), .SCLK_IN(sclk), .CS_N_IN(cs_n), .MOSI_IN(mosi),
		.MISO_OUT(miso), .HARD_RST_N_IN(hard_rst_n), .SAMPLE_TICK_IN(tick),
		.SUPPLY_LOW_IN(cond[0]), .FLASH_FAIL_IN(cond[1]), .OVER_RANGE_IN(cond[2]),
		.SELF_TEST_FAIL_IN(cond[3]), .CHECKSUM_FAIL_IN(cond[4]), .ALARM1_IN(cond[5]),
		.ALARM2_IN(cond[6]), .SLEEP_OUT(sleep), .SAMPLING_OUT(sampling));

	ssir_host ssir_host_inst (.SCLK_OUT(sclk), .CS_N_OUT(cs_n), .MOSI_OUT(mosi), .MISO_IN(miso));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// reply of a read arrives in the following word
	task automatic rd(input logic [6:0] a, output logic [15:0] d);
		logic [15:0] x;
		ssir_host_inst.frame({1'b0, a, 8'h00}, 16, x);
		ssir_host_inst.frame(16'h0000, 16, d);
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] v);
		logic [15:0] x;
		ssir_host_inst.frame({1'b1, a, v}, 16, x);
	endtask

	task automatic pulse_tick();
		step(1);
		tick = 1'b1;
		step(1);
		tick = 1'b0;
		step(2);
	endtask

	task automatic t_ident();
		logic [6:0]  a [8] = '{ssir_pkg::ADDR_DIAG, ssir_pkg::ADDR_LOT1, ssir_pkg::ADDR_LOT2,
			ssir_pkg::ADDR_LOT3, ssir_pkg::ADDR_PRODUCT, ssir_pkg::ADDR_SERIAL, 7'h25,
			ssir_pkg::ADDR_SLEEP};
		logic [15:0] e [8] = '{16'h0000, 16'h0A01, 16'h0A02, 16'h0A03, 16'h1234, 16'h270F,
			16'h0000, 16'h0000};
		logic [15:0] d;
		for (int i = 0; i < 8; i++) begin
			rd(a[i], d);
			check("ident", d, e[i]);
		end
	endtask

	task automatic t_flags();
		logic [15:0] d;
		for (int i = 0; i < 7; i++) begin
			cond = 7'(1 << i);
			pulse_tick();
			rd(ssir_pkg::ADDR_DIAG, d);
			check("flag set", d, FLAG[i]);
			rd(ssir_pkg::ADDR_DIAG, d);
			check("flag cleared", d, 16'h0000);
			pulse_tick();
			cond = 7'h00;
			rd(ssir_pkg::ADDR_DIAG, d);
			check("flag after drop", d, (i == 0) ? 16'h0000 : FLAG[i]);
		end
	endtask

	task automatic t_comm();
		logic [15:0] x;
		logic [15:0] d;
		ssir_host_inst.frame(16'h0000, 32, x);
		rd(ssir_pkg::ADDR_DIAG, d);
		check("whole words", d, 16'h0000);
		ssir_host_inst.frame(16'h0000, 17, x);
		rd(ssir_pkg::ADDR_DIAG, d);
		check("partial word", d, 16'h0008);
		rd(ssir_pkg::ADDR_DIAG, d);
		check("comm cleared", d, 16'h0000);
	endtask

	task automatic t_sleep();
		logic [15:0] d;
		wr(ssir_pkg::ADDR_SLEEP, 8'hFF);
		step(20);
		check("asleep", {14'h0000, sleep, sampling}, 16'h0002);
		cond = 7'h04;
		pulse_tick();
		cond = 7'h00;
		rd(ssir_pkg::ADDR_DIAG, d);
		check("no flag asleep", d, 16'h0000);
		check("woken by select", {14'h0000, sleep, sampling}, 16'h0001);
		cond = 7'h04;
		pulse_tick();
		cond = 7'h00;
		rd(ssir_pkg::ADDR_DIAG, d);
		check("flag after wake", d, 16'h0010);
		wr(ssir_pkg::ADDR_SLEEP, 8'hFF);
		step(20);
		check("asleep again", {14'h0000, sleep, sampling}, 16'h0002);
		hard_rst_n = 1'b0;
		step(4);
		hard_rst_n = 1'b1;
		step(10);
		check("woken by reset pin", {14'h0000, sleep, sampling}, 16'h0001);
	endtask

	task automatic t_timed();
		logic [7:0]  v [4] = '{8'h00, 8'h01, 8'h05, 8'hFE};
		int          n;
		logic [15:0] ok;
		logic [15:0] d;
		for (int i = 0; i < 4; i++) begin
			last_run = 0;
			wr(ssir_pkg::ADDR_SLEEP, v[i]);
			n = 0;
			while (last_run == 0 && n < 2200) begin
				step(1);
				n++;
			end
			ok = 16'(last_run >= v[i] * STEP && last_run <= v[i] * STEP + 2);
			check("timed length", ok, 16'h0001);
		end
		// a long timed sleep cut short by the select of a read
		wr(ssir_pkg::ADDR_SLEEP, 8'hFE);
		step(20);
		check("timed asleep", {14'h0000, sleep, sampling}, 16'h0002);
		rd(ssir_pkg::ADDR_SLEEP, d);
		check("timed cut by select", {14'h0000, sleep, sampling}, 16'h0001);
		check("sleep byte", d, 16'h00FE);
	endtask

	// sleep run lengths and hang guard, sampled away from the launching edge
	always @(negedge clk) begin
		cycles++;
		if (sleep === 1'b1)
			run++;
		else begin
			if (run != 0)
				last_run = run;
			run = 0;
		end
		if (cycles == 40000) begin
			mismatches++;
			final_report();
		end
	end

	initial begin
		sys_rst = 1'b1;
		hard_rst_n = 1'b1;
		tick = 1'b0;
		cond = 7'h00;
		mismatches = 0;
		n_checks = 0;
		cycles = 0;
		run = 0;
		last_run = 0;
		step(10);
		sys_rst = 1'b0;
		step(5);
		t_ident();
		t_flags();
		t_comm();
		t_sleep();
		t_timed();
		final_report();
	end
endmodule // tb
`default_nettype wire
